// ===== hw/aws_top.sv
// Alarm comparator, watchdog and reset supervisor with APB register access
//
// Behaviour
// - Alarm month, date, hour, minute, second and repeat bits live at offsets 6 to 2.
// - Repeat bits select second, minute, hour, day, month or year matching.
// - Undefined repeat patterns behave as once per second.
// - A time match under the repeat mode sets the alarm flag.
// - Alarm match with interrupt enable drives the open-drain interrupt pin low.
// - Flags read releases alarm interrupt; cleared flag shows on the next read.
// - In backup mode interrupt needs both backup enable and interrupt enable.
// - Power-up clears backup enable and interrupt enable; alarm then only sets flag.
// - Watchdog register holds multiplier in bits 6..2, resolution code in 1..0.
// - Time-out equals multiplier times resolution, within one resolution step.
// - Expiry sets watchdog flag bit 7 of flags; flags read clears it.
// - Steering zero raises interrupt; steering one pulses reset low 40-200 ms.
// - Reset-steered time-out clears watchdog register, enables and frequency test at end.
// - Watchdog input edges before time-out and watchdog register writes restart the count.
// - Writing 00h after interrupt time-out releases interrupt and disables watchdog.
// - Power-down disables the watchdog and clears its register.
// - Watchdog or alarm interrupt beats frequency-test output on the shared pin.
// - Power fail holds reset low, and recovery time after supply returns.
// - Either reset input low gives the power-cycle reset; ignored during the recovery time.
// - Fast reset input acts on 200 ns pulses, rejects under 50 ns.
// - Slow reset input acts on 100 ms pulses, rejects under 20 ms.
// - Flags offset 0 holds watchdog flag bit 7, alarm flag bit 6, read-only.
// - Alarm interrupt enable is bit 7, backup enable bit 5 of alarm month.
`timescale 1ns/10ps
`include "aws_cfg.svh"

// Low-level qualifier: pulse input must stay low CYC synced samples
module aws_low_filter #(
  parameter int CYC = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Input level and gating
  input wire logic in_n,
  input wire logic enable,
  // Qualified result
  output logic qualified
);
  logic [31:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 32'h0000_0000;
    end else if (in_n || !enable) begin
      cnt_r <= 32'h0000_0000;
    end else if (cnt_r < 32'(CYC)) begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  assign qualified = (cnt_r >= 32'(CYC));
endmodule : aws_low_filter

module aws_top #(
  parameter int CLK_HZ = `AWS_CLK_HZ,
  parameter int OSC_HZ = `AWS_OSC_HZ,
  parameter int SLOW_CYC = `AWS_SLOW_CYC,
  parameter int RST_PULSE_CYC = `AWS_RST_PULSE_CYC,
  parameter int ADDR_W = 12
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Time base from the clock counters
  input wire aws_pkg::aws_time_t current_time,
  input wire logic second_tick,
  // Pins
  input wire logic watchdog_kick_input,
  input wire logic fast_reset_in_n,
  input wire logic slow_reset_in_n,
  input wire logic supply_below_trip,
  output aws_pkg::aws_od_pin_t irq_freqtest_pin,
  output aws_pkg::aws_od_pin_t reset_out_pin
);
  localparam int FAST_CYC = `AWS_FAST_CYC;

  // Synchronisers
  logic [2:0] kick_sync_r;
  logic [1:0] fast_sync_r;
  logic [1:0] slow_sync_r;
  logic [1:0] pf_sync_r;
  logic pf_prev_r;
  logic kick_edge;
  logic power_fail;
  logic power_up;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kick_sync_r <= 3'b000;
      fast_sync_r <= 2'b11;
      slow_sync_r <= 2'b11;
      pf_sync_r <= 2'b00;
      pf_prev_r <= 1'b0;
    end else begin
      kick_sync_r <= {kick_sync_r[1:0], watchdog_kick_input};
      fast_sync_r <= {fast_sync_r[0], fast_reset_in_n};
      slow_sync_r <= {slow_sync_r[0], slow_reset_in_n};
      pf_sync_r <= {pf_sync_r[0], supply_below_trip};
      pf_prev_r <= pf_sync_r[1];
    end
  end

  assign kick_edge = kick_sync_r[2] ^ kick_sync_r[1];
  assign power_fail = pf_sync_r[1];
  assign power_up = pf_prev_r && !pf_sync_r[1];

  // APB decode
  logic setup;
  logic access;
  logic [`AWS_IDX_W-1:0] idx;
  logic hit;
  logic [7:0] rdata;
  logic [31:0] prdata_r;
  logic hit_r;
  logic wr_en;
  logic flags_read;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign idx = paddr[`AWS_IDX_W+1:2];

  always_comb begin
    hit = (paddr[ADDR_W-1:`AWS_IDX_W+2] == '0) && (paddr[1:0] == 2'b00);
    case (idx)
      `AWS_IDX_FLAGS, `AWS_IDX_ALM_SEC, `AWS_IDX_ALM_MIN, `AWS_IDX_ALM_HOUR,
      `AWS_IDX_ALM_DATE, `AWS_IDX_ALM_MONTH, `AWS_IDX_WDOG, `AWS_IDX_CTRL: hit = hit;
      default: hit = 1'b0;
    endcase
  end

  assign wr_en = access && pwrite && hit_r;
  assign flags_read = access && !pwrite && hit_r && (idx == `AWS_IDX_FLAGS);
  assign pready = 1'b1;
  assign pslverr = access && !hit_r;
  assign prdata = prdata_r;

  // Registers
  logic [7:0] alm_r [0:4];
  logic [7:0] wd_reg_r;
  logic freq_test_r;
  logic af_r;
  logic wdf_r;
  logic wd_end;
  logic wd_expire;

  always_comb begin
    rdata = 8'h00;
    case (idx)
      `AWS_IDX_FLAGS: begin
        rdata[`AWS_FLAG_WDF] = wdf_r;
        rdata[`AWS_FLAG_AF] = af_r;
      end
      `AWS_IDX_ALM_SEC, `AWS_IDX_ALM_MIN, `AWS_IDX_ALM_HOUR, `AWS_IDX_ALM_DATE,
      `AWS_IDX_ALM_MONTH: rdata = alm_r[3'(idx - `AWS_IDX_ALM_SEC)];
      `AWS_IDX_WDOG: rdata = wd_reg_r;
      `AWS_IDX_CTRL: begin
        rdata[`AWS_CTRL_FT] = freq_test_r;
        rdata[`AWS_CTRL_PF] = power_fail;
      end
      default: rdata = 8'h00;
    endcase
  end

  // Read data captured in setup, so access completes with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      hit_r <= 1'b0;
    end else if (setup) begin
      // Refused reads return zero even when the low index bits alias a register
      prdata_r <= {24'h00_0000, hit ? rdata : 8'h00};
      hit_r <= hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 5; i++) begin
        alm_r[i] <= `AWS_RESET_BYTE;
      end
    end else begin
      if (wr_en && idx >= `AWS_IDX_ALM_SEC && idx <= `AWS_IDX_ALM_MONTH) begin
        alm_r[3'(idx - `AWS_IDX_ALM_SEC)] <= pwdata[7:0];
      end
      if (power_up || wd_end) begin
        alm_r[4][`AWS_MON_AFE] <= 1'b0;
        alm_r[4][`AWS_MON_ABE] <= 1'b0;
      end
    end
  end

  // frequency test cleared with reset-steered time-out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_test_r <= 1'b0;
    end else if (wd_end || power_up) begin
      freq_test_r <= 1'b0;
    end else if (wr_en && idx == `AWS_IDX_CTRL) begin
      freq_test_r <= pwdata[`AWS_CTRL_FT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_reg_r <= `AWS_RESET_BYTE;
    end else if (power_fail || wd_end) begin
      wd_reg_r <= `AWS_RESET_BYTE;
    end else if (wr_en && idx == `AWS_IDX_WDOG) begin
      wd_reg_r <= pwdata[7:0];
    end
  end

  logic [31:0] phase_r;
  logic osc_tick;
  logic [16:0] osc_cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 32'h0000_0000;
      osc_tick <= 1'b0;
    end else if (phase_r + 32'(OSC_HZ) >= 32'(CLK_HZ)) begin
      phase_r <= phase_r + 32'(OSC_HZ) - 32'(CLK_HZ);
      osc_tick <= 1'b1;
    end else begin
      phase_r <= phase_r + 32'(OSC_HZ);
      osc_tick <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_r <= 17'h0_0000;
    end else if (osc_tick) begin
      osc_cnt_r <= osc_cnt_r + 17'h0_0001;
    end
  end

  logic res_tick;
  always_comb begin
    case (wd_reg_r[1:0])
      2'b00: res_tick = osc_tick && (&osc_cnt_r[10:0]);
      2'b01: res_tick = osc_tick && (&osc_cnt_r[12:0]);
      2'b10: res_tick = osc_tick && (&osc_cnt_r[14:0]);
      default: res_tick = osc_tick && (&osc_cnt_r);
    endcase
  end

  // Watchdog countdown
  logic [4:0] wd_cnt_r;
  logic wd_done_r;
  logic wd_irq_r;
  logic wd_wr;
  logic [4:0] mult;

  assign wd_wr = wr_en && (idx == `AWS_IDX_WDOG);
  assign mult = wd_reg_r[`AWS_WD_MULT_HI:`AWS_WD_MULT_LO];
  assign wd_expire = res_tick && !wd_done_r && !power_fail && mult != 5'h00 && !wd_wr && !kick_edge
                     && wd_cnt_r <= 5'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_r <= 5'h00;
      wd_done_r <= 1'b0;
    end else if (wd_wr) begin
      wd_cnt_r <= pwdata[`AWS_WD_MULT_HI:`AWS_WD_MULT_LO];
      wd_done_r <= 1'b0;
    end else if (kick_edge) begin
      wd_cnt_r <= mult;
    end else if (wd_expire) begin
      wd_done_r <= 1'b1;
    end else if (res_tick && !wd_done_r && wd_cnt_r != 5'h00) begin
      wd_cnt_r <= wd_cnt_r - 5'h01;
    end
  end

  // interrupt-steered time-out, released by register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_irq_r <= 1'b0;
    end else if (wd_expire && !wd_reg_r[`AWS_WD_STEER]) begin
      wd_irq_r <= 1'b1;
    end else if (wd_wr || power_fail) begin
      wd_irq_r <= 1'b0;
    end
  end

  // Alarm match
  logic [4:0] rpt;
  aws_pkg::aws_rpt_t mode;
  logic match;
  logic alarm_irq_r;

  assign rpt = {alm_r[3][`AWS_DATE_RPT5], alm_r[3][`AWS_RPT_BIT], alm_r[2][`AWS_RPT_BIT],
                alm_r[1][`AWS_RPT_BIT], alm_r[0][`AWS_RPT_BIT]};

  always_comb begin
    case (rpt)
      5'b11110: mode = aws_pkg::AWS_RPT_MIN;
      5'b11100: mode = aws_pkg::AWS_RPT_HOUR;
      5'b11000: mode = aws_pkg::AWS_RPT_DAY;
      5'b10000: mode = aws_pkg::AWS_RPT_MONTH;
      5'b00000: mode = aws_pkg::AWS_RPT_YEAR;
      default: mode = aws_pkg::AWS_RPT_SEC;
    endcase
  end

  always_comb begin
    logic s_eq;
    logic m_eq;
    logic h_eq;
    logic d_eq;
    logic mo_eq;
    s_eq = current_time.second[6:0] == alm_r[0][6:0];
    m_eq = current_time.minute[6:0] == alm_r[1][6:0];
    h_eq = current_time.hour[5:0] == alm_r[2][5:0];
    d_eq = current_time.date[5:0] == alm_r[3][5:0];
    mo_eq = current_time.month[4:0] == alm_r[4][4:0];
    case (mode)
      aws_pkg::AWS_RPT_MIN: match = s_eq;
      aws_pkg::AWS_RPT_HOUR: match = s_eq && m_eq;
      aws_pkg::AWS_RPT_DAY: match = s_eq && m_eq && h_eq;
      aws_pkg::AWS_RPT_MONTH: match = s_eq && m_eq && h_eq && d_eq;
      aws_pkg::AWS_RPT_YEAR: match = s_eq && m_eq && h_eq && d_eq && mo_eq;
      default: match = 1'b1;
    endcase
    match = match && second_tick;
  end

  // sticky flags; set wins over the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      af_r <= 1'b0;
      wdf_r <= 1'b0;
    end else begin
      af_r <= match || (af_r && !flags_read);
      wdf_r <= wd_expire || (wdf_r && !flags_read);
    end
  end

  // alarm interrupt, released by a flags read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_irq_r <= 1'b0;
    end else if (match && alm_r[4][`AWS_MON_AFE] && (!power_fail || alm_r[4][`AWS_MON_ABE])) begin
      alarm_irq_r <= 1'b1;
    end else if (flags_read) begin
      alarm_irq_r <= 1'b0;
    end
  end

  // Frequency test square wave and interrupt pin
  logic ft_wave_r;
  logic irq_oe_r;
  logic ft_allowed;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ft_wave_r <= 1'b0;
    end else if (osc_tick && (&osc_cnt_r[4:0])) begin
      ft_wave_r <= !ft_wave_r;
    end
  end

  assign ft_allowed = freq_test_r && !alm_r[4][`AWS_MON_AFE] && !power_fail
                      && (wd_reg_r[`AWS_WD_STEER] || wd_reg_r == 8'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_oe_r <= 1'b0;
    end else if (alarm_irq_r || wd_irq_r) begin
      irq_oe_r <= 1'b1;
    end else begin
      irq_oe_r <= ft_allowed && !ft_wave_r;
    end
  end

  assign irq_freqtest_pin = '{o: 1'b0, oe: irq_oe_r};

  // Reset output sequencing
  aws_pkg::aws_rst_state_t rst_state_r;
  logic [31:0] rst_cnt_r;
  logic rst_src_wd_r;
  logic fast_q;
  logic slow_q;
  logic inputs_live;

  assign inputs_live = (rst_state_r == aws_pkg::AWS_RS_IDLE);

  aws_low_filter #(.CYC(FAST_CYC)) u_fast_filter (
    .pclk(pclk),
    .presetn(presetn),
    .in_n(fast_sync_r[1]),
    .enable(inputs_live),
    .qualified(fast_q)
  );

  aws_low_filter #(.CYC(SLOW_CYC)) u_slow_filter (
    .pclk(pclk),
    .presetn(presetn),
    .in_n(slow_sync_r[1]),
    .enable(inputs_live),
    .qualified(slow_q)
  );

  assign wd_end = (rst_state_r == aws_pkg::AWS_RS_TIMED) && rst_src_wd_r
                  && (rst_cnt_r == 32'(RST_PULSE_CYC - 1)) && !power_fail;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_state_r <= aws_pkg::AWS_RS_IDLE;
      rst_cnt_r <= 32'h0000_0000;
      rst_src_wd_r <= 1'b0;
    end else begin
      case (rst_state_r)
        aws_pkg::AWS_RS_IDLE: begin
          rst_cnt_r <= 32'h0000_0000;
          if (power_fail || fast_q || slow_q) begin
            rst_state_r <= aws_pkg::AWS_RS_HOLD;
            rst_src_wd_r <= 1'b0;
          end else if (wd_expire && wd_reg_r[`AWS_WD_STEER]) begin
            rst_state_r <= aws_pkg::AWS_RS_TIMED;
            rst_src_wd_r <= 1'b1;
          end
        end
        aws_pkg::AWS_RS_HOLD: begin
          rst_cnt_r <= 32'h0000_0000;
          if (!power_fail && fast_sync_r[1] && slow_sync_r[1]) begin
            rst_state_r <= aws_pkg::AWS_RS_TIMED;
          end
        end
        aws_pkg::AWS_RS_TIMED: begin
          if (power_fail) begin
            rst_state_r <= aws_pkg::AWS_RS_HOLD;
            rst_src_wd_r <= 1'b0;
          end else if (rst_cnt_r == 32'(RST_PULSE_CYC - 1)) begin
            rst_state_r <= aws_pkg::AWS_RS_IDLE;
            rst_src_wd_r <= 1'b0;
          end else begin
            rst_cnt_r <= rst_cnt_r + 32'h0000_0001;
          end
        end
        default: begin
          rst_state_r <= aws_pkg::AWS_RS_IDLE;
        end
      endcase
    end
  end

  assign reset_out_pin = '{o: 1'b0, oe: (rst_state_r != aws_pkg::AWS_RS_IDLE)};
endmodule : aws_top

// ===== hw/aws_cfg.svh
// Register offsets, field positions and timing figures of the alarm, watchdog and reset supervisor
`ifndef AWS_CFG_SVH
`define AWS_CFG_SVH

`define AWS_IDX_W 5
`define AWS_IDX_FLAGS 5'h00
`define AWS_IDX_ALM_SEC 5'h02
`define AWS_IDX_ALM_MIN 5'h03
`define AWS_IDX_ALM_HOUR 5'h04
`define AWS_IDX_ALM_DATE 5'h05
`define AWS_IDX_ALM_MONTH 5'h06
`define AWS_IDX_WDOG 5'h07
`define AWS_IDX_CTRL 5'h10

`define AWS_FLAG_WDF 7
`define AWS_FLAG_AF 6
`define AWS_MON_AFE 7
`define AWS_MON_ABE 5
`define AWS_RPT_BIT 7
`define AWS_DATE_RPT5 6
`define AWS_WD_STEER 7
`define AWS_WD_MULT_HI 6
`define AWS_WD_MULT_LO 2
`define AWS_CTRL_FT 0
`define AWS_CTRL_PF 1
`define AWS_RESET_BYTE 8'h00

`define AWS_CLK_HZ 20000000
`define AWS_CLK_PERIOD_NS 50
`define AWS_OSC_HZ 32768
`define AWS_FAST_MIN_NS 200
`define AWS_FAST_CYC (`AWS_FAST_MIN_NS / `AWS_CLK_PERIOD_NS)
`define AWS_SLOW_MIN_MS 100
`define AWS_SLOW_CYC (`AWS_SLOW_MIN_MS * 1000000 / `AWS_CLK_PERIOD_NS)
`define AWS_RST_PULSE_MS 100
`define AWS_RST_PULSE_CYC (`AWS_RST_PULSE_MS * 1000000 / `AWS_CLK_PERIOD_NS)
`define AWS_FT_HALF_OSC 32

`endif

// ===== hw/aws_pkg.sv
// Types shared by the alarm, watchdog and reset supervisor
package aws_pkg;

  typedef struct packed {
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } aws_time_t;

  typedef struct packed {
    logic o;
    logic oe;
  } aws_od_pin_t;

  typedef enum logic [2:0] {
    AWS_RPT_SEC = 3'b000,
    AWS_RPT_MIN = 3'b001,
    AWS_RPT_HOUR = 3'b010,
    AWS_RPT_DAY = 3'b011,
    AWS_RPT_MONTH = 3'b100,
    AWS_RPT_YEAR = 3'b101
  } aws_rpt_t;

  typedef enum logic [1:0] {
    AWS_RS_IDLE = 2'b00,
    AWS_RS_HOLD = 2'b01,
    AWS_RS_TIMED = 2'b10
  } aws_rst_state_t;

endpackage : aws_pkg

// ===== bench/aws_top_checker.sv
// Port-level assertions for the supervisor block
`timescale 1ns/10ps
module aws_top_checker #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic supply_below_trip,
  input wire aws_pkg::aws_od_pin_t irq_freqtest_pin,
  input wire aws_pkg::aws_od_pin_t reset_out_pin
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  a_wdog_mapped: assert property (psel && penable && paddr == 12'h01C |-> !pslverr)
    else $error("watchdog register refused");
  a_hole_err: assert property (psel && penable && paddr == 12'h004 |-> pslverr)
    else $error("unmapped access accepted");
  a_err_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  a_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_od_sink: assert property (!irq_freqtest_pin.o && !reset_out_pin.o)
    else $error("open drain drives high");
  a_rst_hold: assert property ($rose(reset_out_pin.oe) |-> reset_out_pin.oe [*8])
    else $error("reset pulse too short");
  a_fail_rst: assert property (supply_below_trip [*6] |-> reset_out_pin.oe)
    else $error("no reset on power fail");
  cover property ($rose(irq_freqtest_pin.oe));
  cover property ($rose(reset_out_pin.oe));
  cover property (pslverr);
endmodule : aws_top_checker

// ===== bench/aws_host_model.sv
// Host-side pin model: kick source, reset pulser, pull-ups
`timescale 1ns/10ps
module aws_host_model (
  // Clock
  input wire logic pclk,
  // Bench commands
  input wire logic kick_en,
  input wire logic [7:0] pulse_len,
  input wire logic pulse_go,
  input wire logic pulse_slow,
  // Pins
  input wire aws_pkg::aws_od_pin_t irq_pin,
  input wire aws_pkg::aws_od_pin_t rst_pin,
  output logic kick,
  output logic fast_n,
  output logic slow_n,
  output logic irq_n,
  output logic rst_n
);
  int kcnt = 0;
  logic [7:0] pcnt = 8'h00;
  // Pull-ups hold the lines unless sunk
  assign irq_n = irq_pin.oe ? irq_pin.o : 1'b1;
  assign rst_n = rst_pin.oe ? rst_pin.o : 1'b1;
  initial begin
    kick = 1'b0;
    fast_n = 1'b1;
    slow_n = 1'b1;
  end
  always @(posedge pclk) begin
    kcnt <= kcnt + 1;
    if (kick_en && kcnt % 1000 == 0) kick <= ~kick;
  end
  always @(posedge pclk) begin
    if (pulse_go) begin
      pcnt <= pulse_len;
      fast_n <= pulse_slow;
      slow_n <= !pulse_slow;
    end else if (pcnt > 8'h01) pcnt <= pcnt - 8'h01;
    else begin
      pcnt <= 8'h00;
      fast_n <= 1'b1;
      slow_n <= 1'b1;
    end
  end
endmodule : aws_host_model

// ===== bench/tb_top.sv
// Self-checking bench for the supervisor block
`timescale 1ns/10ps
module tb_top;
  localparam int RPC = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  aws_pkg::aws_time_t current_time;
  logic second_tick, supply_below_trip, kick, fast_n, slow_n, irq_n, rst_n;
  logic kick_en, pulse_go, pulse_slow;
  logic [7:0] pulse_len, rq;
  logic re;
  aws_pkg::aws_od_pin_t irq_pin, rst_pin;
  int n_fail = 0;
  int checks = 0;
  int n;
  // Short counts keep the run small
  aws_top #(.CLK_HZ(64), .OSC_HZ(32), .SLOW_CYC(50), .RST_PULSE_CYC(RPC)) i_dut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .current_time,
    .second_tick, .watchdog_kick_input(kick), .fast_reset_in_n(fast_n), .slow_reset_in_n(slow_n),
    .supply_below_trip, .irq_freqtest_pin(irq_pin), .reset_out_pin(rst_pin));
  aws_host_model i_host (.pclk, .kick_en, .pulse_len, .pulse_go, .pulse_slow, .irq_pin, .rst_pin, .kick,
    .fast_n, .slow_n, .irq_n, .rst_n);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task test_done;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rq = prdata[7:0];
    re = pslverr;
    if (k >= 20) chk(k, 0);
    if (k >= 20) test_done();
    // bus released between transfers so flags are presented afresh
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Waits for a pin to go low, counting cycles
  task automatic wait_low(input logic rs, input int lim);
    n = 0;
    while ((rs ? rst_n : irq_n) !== 1'b0) begin
      @(posedge pclk);
      n++;
      if (n > lim) chk(n, lim);
      if (n > lim) test_done();
    end
  endtask : wait_low
  task automatic hold_cnt;
    n = 0;
    while (rst_n !== 1'b1) begin
      @(posedge pclk);
      n++;
      if (n > 200) chk(n, 200);
      if (n > 200) test_done();
    end
  endtask : hold_cnt
  task automatic pulse(input logic slow, input logic [7:0] len, input logic acts);
    @(posedge pclk);
    pulse_slow <= slow;
    pulse_len <= len;
    pulse_go <= 1'b1;
    @(posedge pclk);
    pulse_go <= 1'b0;
    repeat (len + 8) @(posedge pclk);
    chk(rst_n, !acts);
    hold_cnt();
    if (acts) chk(32'(n >= RPC - 4), 1);
  endtask : pulse
  task automatic t_regs;
    apb(0, 12'h000, 8'h00);
    chk(rq, 0);
    apb(0, 12'h01C, 8'h00);
    chk(rq, 0);
    apb(0, 12'h018, 8'h00);
    chk(rq, 0);
    apb(0, 12'h004, 8'h00);
    chk({re, rq}, 9'h100);
    $display("register defaults done");
  endtask : t_regs
  task automatic alm(input logic [39:0] regs, input logic [7:0] sec, input logic hit);
    for (int i = 0; i < 5; i++) apb(1, 12'h008 + 12'(4 * i), regs[8*i+:8]);
    @(posedge pclk);
    current_time.second <= sec;
    second_tick <= 1'b1;
    @(posedge pclk);
    second_tick <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(irq_n, !hit);
    apb(0, 12'h000, 8'h00);
    chk(rq, hit ? 8'h40 : 8'h00);
    repeat (2) @(posedge pclk);
    chk(irq_n, 1);
    apb(0, 12'h000, 8'h00);
    chk(rq, 0);
  endtask : alm
  task automatic t_alarm;
    alm(40'h80_C080_8080, 8'h33, 1);
    alm(40'h80_C080_8005, 8'h06, 0);
    alm(40'h80_C080_8005, 8'h05, 1);
    alm(40'h80_C080_0205, 8'h05, 0);
    alm(40'h80_C002_0105, 8'h05, 0);
    alm(40'h80_4201_0105, 8'h05, 0);
    alm(40'h80_4101_0105, 8'h05, 1);
    alm(40'h80_0000_0080, 8'h06, 1);
    alm(40'h82_0101_0105, 8'h05, 0);
    alm(40'h81_0101_0105, 8'h05, 1);
    alm(40'h00_0000_0000, 8'h05, 0);
    $display("alarm done");
  endtask : t_alarm
  task automatic t_ftest;
    apb(1, 12'h040, 8'h01);
    wait_low(0, 200);
    apb(1, 12'h018, 8'h80);
    repeat (3) @(posedge pclk);
    n = 0;
    repeat (200) begin
      @(posedge pclk);
      if (irq_n !== 1'b1) n++;
    end
    chk(n, 0);
    apb(1, 12'h040, 8'h00);
    apb(1, 12'h018, 8'h00);
    $display("frequency test done");
  endtask : t_ftest
  task automatic t_wdog;
    apb(1, 12'h01C, 8'h08);
    kick_en <= 1'b1;
    repeat (12000) @(posedge pclk);
    chk(irq_n, 1);
    kick_en <= 1'b0;
    wait_low(0, 9000);
    chk(32'(n >= 3000), 1);
    apb(0, 12'h000, 8'h00);
    chk(rq, 8'h80);
    apb(0, 12'h000, 8'h00);
    chk({irq_n, rq}, 9'h000);
    apb(1, 12'h01C, 8'h00);
    repeat (2) @(posedge pclk);
    chk(irq_n, 1);
    repeat (9000) @(posedge pclk);
    chk(irq_n, 1);
    $display("watchdog interrupt done");
  endtask : t_wdog
  task automatic t_steer;
    apb(1, 12'h018, 8'hA0);
    apb(1, 12'h040, 8'h01);
    apb(1, 12'h01C, 8'h88);
    wait_low(1, 9000);
    hold_cnt();
    chk(32'(n >= RPC && n <= RPC + 3), 1);
    apb(0, 12'h01C, 8'h00);
    chk(rq, 0);
    apb(0, 12'h018, 8'h00);
    chk(rq, 0);
    apb(0, 12'h040, 8'h00);
    chk(rq, 0);
    apb(0, 12'h000, 8'h00);
    chk(rq, 8'h80);
    $display("watchdog reset done");
  endtask : t_steer
  task automatic t_pins;
    pulse(0, 8'h01, 0);
    pulse(0, 8'h06, 1);
    pulse(1, 8'h08, 0);
    pulse(1, 8'h3C, 1);
    apb(1, 12'h01C, 8'h08);
    apb(1, 12'h018, 8'hA0);
    apb(1, 12'h040, 8'h01);
    @(posedge pclk);
    supply_below_trip <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(rst_n, 0);
    supply_below_trip <= 1'b0;
    hold_cnt();
    chk(32'(n >= RPC), 1);
    apb(0, 12'h01C, 8'h00);
    chk(rq, 0);
    apb(0, 12'h018, 8'h00);
    chk(rq, 0);
    apb(0, 12'h040, 8'h00);
    chk(rq, 0);
    $display("reset pins done");
  endtask : t_pins
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, second_tick, supply_below_trip, kick_en, pulse_go, pulse_slow} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pulse_len = 8'h00;
    current_time = 40'h01_0101_0100;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_alarm();
    t_ftest();
    t_wdog();
    t_steer();
    t_pins();
    test_done();
  end
endmodule : tb_top
bind aws_top aws_top_checker #(.ADDR_W(ADDR_W)) i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .supply_below_trip, .irq_freqtest_pin, .reset_out_pin);
